// ---- osp_map.svh ----
// register offsets, reset values and timing counts of the option setup bank
`ifndef OSP_MAP_SVH
`define OSP_MAP_SVH

// register byte offsets
`define OSP_OFS_WATCHDOG_KICK_COMMAND_EN    8'h00
`define OSP_OFS_SAVE_REQ   8'h04
`define OSP_OFS_UV_SAVE    8'h08
`define OSP_OFS_MENU_SAVE  8'h0C
`define OSP_OFS_RING_ID    8'h10
`define OSP_OFS_NODE_ADDR  8'h14
`define OSP_OFS_DATA_RATE  8'h18
`define OSP_OFS_SYNC_SETUP 8'h1C
`define OSP_OFS_EASY_BASE  8'h20
`define OSP_OFS_INC_BASE   8'h38
`define OSP_OFS_STATUS     8'h44

// easy-mode channel stride: destination then source per channel
`define OSP_EASY_STRIDE    8'h08
`define OSP_EASY_SRC_OFS   8'h04
`define OSP_WORD_STRIDE    8'h04

// reset values
`define OSP_RST_DATA_RATE  2'h1
`define OSP_RST_SET_MASK   4'hF

// range limits
`define OSP_DEST_MAX       32'd25503
`define OSP_PARAM_MAX      32'd9999
`define OSP_DIGIT_PAIR     15'd100

// status register field positions
`define OSP_ST_ARMED       0
`define OSP_ST_BUSY        1
`define OSP_ST_NET_EN      2

// timing
`define OSP_CLK_KHZ        100000
`define OSP_WATCHDOG_KICK_COMMAND_MS        200
`define OSP_WATCHDOG_KICK_COMMAND_CYC       (`OSP_WATCHDOG_KICK_COMMAND_MS * `OSP_CLK_KHZ)
`define OSP_MS_CYC         (`OSP_CLK_KHZ)

// link data rates in kbit/s and cycles per bit derived from the clock
`define OSP_RATE0_KBPS     5000
`define OSP_RATE1_KBPS     2500
`define OSP_RATE2_KBPS     1250
`define OSP_RATE3_KBPS     625
`define OSP_BIT_CYC(k)     (`OSP_CLK_KHZ / (k))

`endif

// ---- osp_pkg.sv ----
// types shared by the option setup bank
package osp_pkg;
  typedef enum logic [1:0] {OSP_IDLE, OSP_SAVE, OSP_WAIT, OSP_RESET} osp_save_e;
  typedef logic [14:0] osp_easy_t;
  typedef logic [7:0]  osp_addr_t;
  typedef logic [31:0] osp_word_t;
endpackage

// ---- osp_setup_params.sv ----
// setup parameter bank: watchdog, non-volatile save control, ring network setup
//
// Implementation choices: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
`include "osp_map.svh"

module osp_setup_params #(
  parameter int unsigned WATCHDOG_KICK_COMMAND_CYC = `OSP_WATCHDOG_KICK_COMMAND_CYC,
  parameter int unsigned MS_CYC   = `OSP_MS_CYC
) (
  input  wire logic                    ref_clk,
  input  wire logic                    arst_n,
  input  wire osp_pkg::osp_addr_t      reg_addr,
  input  wire osp_pkg::osp_word_t      reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output osp_pkg::osp_word_t           reg_rdata,
  input  wire logic                    watchdog_kick_command,
  input  wire logic                    undervoltage_trip,
  input  wire logic                    save_done,
  output logic                         slot_timeout_trip,
  output logic                         drive_trip_clear,
  output logic                         module_reset,
  output logic                         save_start,
  output logic                         save_busy,
  output logic                         save_menu20,
  output logic [3:0]                   save_set_mask,
  output logic                         net_enable,
  output logic [7:0]                   ring_identity_out,
  output logic [7:0]                   node_address_out,
  output logic [7:0]                   bit_period_cyc,
  output logic                         sync_fast_tick,
  output logic                         sync_slow_tick,
  output logic [2:0][7:0]              easy_dest_node,
  output logic [2:0][6:0]              easy_dest_slot,
  output logic [2:0][6:0]              easy_src_menu,
  output logic [2:0][6:0]              easy_src_param,
  output logic [2:0][6:0]              easy_inc_menu,
  output logic [2:0][6:0]              easy_inc_param
);
  import osp_pkg::*;

  // upper decimal digits and lower two digits of a stored value
  function automatic logic [7:0] osp_hi(input osp_easy_t v);
    osp_hi = 8'(v / `OSP_DIGIT_PAIR);
  endfunction

  function automatic logic [6:0] osp_lo(input osp_easy_t v);
    osp_lo = 7'(v % `OSP_DIGIT_PAIR);
  endfunction

  // writes above range are limited to the maximum rather than ignored
  function automatic osp_easy_t osp_clamp(input osp_word_t w, input osp_word_t lim);
    osp_clamp = (w > lim) ? 15'(lim) : 15'(w);
  endfunction

  // software-visible settings
  logic        wd_en_ff, save_req_ff, uv_en_ff, menu_en_ff;
  logic [7:0]  ring_ff, node_ff;
  logic [1:0]  rate_ff;
  osp_easy_t   sync_ff;
  osp_easy_t   dest_ff [3];
  osp_easy_t   src_ff  [3];
  osp_easy_t   inc_ff  [3];

  // settings taken over at initialisation
  logic        wd_en_act_ff;
  logic [6:0]  fast_act_ff;
  logic [7:0]  slow_act_ff;
  logic        boot_ff;

  // save sequencer and watchdog state
  osp_save_e   state_ff, nxt_state;
  logic        by_req_ff;
  logic        armed_ff;
  logic [31:0] wd_cnt_ff;

  // undervoltage pin synchroniser and edge
  logic        uv_s1_ff, uv_s2_ff, uv_s3_ff;

  // sync generator counters
  logic [31:0] ms_cnt_ff;
  logic [6:0]  fast_cnt_ff;
  logic [7:0]  slow_cnt_ff;

  osp_word_t   rdata_ff;

  // address decode
  wire         wr_wd    = reg_wr && (reg_addr == `OSP_OFS_WATCHDOG_KICK_COMMAND_EN);
  wire         wr_save  = reg_wr && (reg_addr == `OSP_OFS_SAVE_REQ);
  wire         wr_uv    = reg_wr && (reg_addr == `OSP_OFS_UV_SAVE);
  wire         wr_menu  = reg_wr && (reg_addr == `OSP_OFS_MENU_SAVE);
  wire         wr_ring  = reg_wr && (reg_addr == `OSP_OFS_RING_ID);
  wire         wr_node  = reg_wr && (reg_addr == `OSP_OFS_NODE_ADDR);
  wire         wr_rate  = reg_wr && (reg_addr == `OSP_OFS_DATA_RATE);
  wire         wr_sync  = reg_wr && (reg_addr == `OSP_OFS_SYNC_SETUP);

  // initialisation load: after reset release and at each module reset
  wire         init_ld  = boot_ff || module_reset;
  wire         uv_rise  = uv_s2_ff && !uv_s3_ff;
  wire         idle     = (state_ff == OSP_IDLE);
  // a trigger is also taken in the reset cycle, so none is lost at the boundary
  wire         take     = idle || (state_ff == OSP_RESET);
  wire         req_go   = wr_save && reg_wdata[0];
  wire         uv_go    = uv_rise && uv_en_ff;
  wire         kick_ok  = watchdog_kick_command && wd_en_act_ff;
  wire         wd_tmo   = armed_ff && !watchdog_kick_command &&
                          (wd_cnt_ff == WATCHDOG_KICK_COMMAND_CYC - 1);
  wire         sync_on  = net_enable && (fast_act_ff != 7'h00);
  wire         ms_tick  = (ms_cnt_ff == MS_CYC - 1);
  wire         fast_end = sync_on && ms_tick && (fast_cnt_ff == fast_act_ff - 7'h01);
  wire         slow_end = fast_end && (slow_act_ff != 8'h00) &&
                          (slow_cnt_ff == slow_act_ff - 8'h01);

  // configuration registers; the two save enables act at once, the rest wait for a reload
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wd_en_ff <= 1'b0;
      uv_en_ff <= 1'b0;
      menu_en_ff <= 1'b0;
      ring_ff <= 8'h00;
      node_ff <= 8'h00;
      rate_ff <= `OSP_RST_DATA_RATE;
      sync_ff <= 15'h0000;
    end else begin
      if (wr_wd) wd_en_ff <= reg_wdata[0];
      if (wr_uv) uv_en_ff <= reg_wdata[0];
      if (wr_menu) menu_en_ff <= reg_wdata[0];
      if (wr_ring) ring_ff <= reg_wdata[7:0];
      if (wr_node) node_ff <= reg_wdata[7:0];
      if (wr_rate) rate_ff <= reg_wdata[1:0];
      if (wr_sync) sync_ff <= osp_clamp(reg_wdata, `OSP_PARAM_MAX);
    end
  end

  // easy-mode channel registers, one set per channel
  // out-of-range writes clamp, so a decoded node number never exceeds 255
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_easy
      wire [7:0] d_ofs = 8'(`OSP_OFS_EASY_BASE + gi * `OSP_EASY_STRIDE);
      wire [7:0] i_ofs = 8'(`OSP_OFS_INC_BASE + gi * `OSP_WORD_STRIDE);
      wire       wr_d  = reg_wr && (reg_addr == d_ofs);
      wire       wr_s  = reg_wr && (reg_addr == 8'(d_ofs + `OSP_EASY_SRC_OFS));
      wire       wr_i  = reg_wr && (reg_addr == i_ofs);

      always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          dest_ff[gi] <= 15'h0000;
          src_ff[gi] <= 15'h0000;
          inc_ff[gi] <= 15'h0000;
        end else begin
          if (wr_d) dest_ff[gi] <= osp_clamp(reg_wdata, `OSP_DEST_MAX);
          if (wr_s) src_ff[gi] <= osp_clamp(reg_wdata, `OSP_PARAM_MAX);
          if (wr_i) inc_ff[gi] <= osp_clamp(reg_wdata, `OSP_PARAM_MAX);
        end
      end

      // decoded channel fields only change at initialisation
      always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          easy_dest_node[gi] <= 8'h00;
          easy_dest_slot[gi] <= 7'h00;
          easy_src_menu[gi] <= 7'h00;
          easy_src_param[gi] <= 7'h00;
          easy_inc_menu[gi] <= 7'h00;
          easy_inc_param[gi] <= 7'h00;
        end else if (init_ld) begin
          easy_dest_node[gi] <= osp_hi(dest_ff[gi]);
          easy_dest_slot[gi] <= osp_lo(dest_ff[gi]);
          easy_src_menu[gi] <= 7'(osp_hi(src_ff[gi]));
          easy_src_param[gi] <= osp_lo(src_ff[gi]);
          easy_inc_menu[gi] <= 7'(osp_hi(inc_ff[gi]));
          easy_inc_param[gi] <= osp_lo(inc_ff[gi]);
        end
      end
    end
  endgenerate

  // network setup taken over at initialisation; later writes wait for a module reset
  // the bit period is a whole number of clocks only while the clock is a multiple
  // of every rate; the slowest rate needs 160 clocks, which still fits 8 bits
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      boot_ff <= 1'b1;
      wd_en_act_ff <= 1'b0;
      ring_identity_out <= 8'h00;
      node_address_out <= 8'h00;
      net_enable <= 1'b0;
      bit_period_cyc <= 8'(`OSP_BIT_CYC(`OSP_RATE1_KBPS));
      fast_act_ff <= 7'h00;
      slow_act_ff <= 8'h00;
    end else begin
      boot_ff <= 1'b0;
      if (init_ld) begin
        wd_en_act_ff <= wd_en_ff;
        ring_identity_out <= ring_ff;
        node_address_out <= node_ff;
        net_enable <= (node_ff != 8'h00);
        fast_act_ff <= osp_lo(sync_ff);
        slow_act_ff <= osp_hi(sync_ff);
        unique case (rate_ff)
          2'h0: bit_period_cyc <= 8'(`OSP_BIT_CYC(`OSP_RATE0_KBPS));
          2'h1: bit_period_cyc <= 8'(`OSP_BIT_CYC(`OSP_RATE1_KBPS));
          2'h2: bit_period_cyc <= 8'(`OSP_BIT_CYC(`OSP_RATE2_KBPS));
          2'h3: bit_period_cyc <= 8'(`OSP_BIT_CYC(`OSP_RATE3_KBPS));
        endcase
      end
    end
  end

  // watchdog: armed by first kick, each kick restarts the full interval
  // the trip lands WATCHDOG_KICK_COMMAND_CYC cycles after the edge that took the last kick;
  // a kick in the timeout cycle itself still wins, so the trip never races it
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      armed_ff <= 1'b0;
      wd_cnt_ff <= 32'h0000_0000;
      slot_timeout_trip <= 1'b0;
    end else begin
      slot_timeout_trip <= wd_tmo;
      if (init_ld || !wd_en_act_ff || wd_tmo) begin
        armed_ff <= 1'b0;
        wd_cnt_ff <= 32'h0000_0000;
      end else if (kick_ok) begin
        armed_ff <= 1'b1;
        wd_cnt_ff <= 32'h0000_0000;
      end else if (armed_ff) begin
        wd_cnt_ff <= wd_cnt_ff + 32'h0000_0001;
      end
    end
  end

  // undervoltage pin: two stages before use, third stage only for the edge
  // all stages reset low like the idle pin, so leaving reset makes no false edge
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      uv_s1_ff <= 1'b0;
      uv_s2_ff <= 1'b0;
      uv_s3_ff <= 1'b0;
    end else begin
      uv_s1_ff <= undervoltage_trip;
      uv_s2_ff <= uv_s1_ff;
      uv_s3_ff <= uv_s2_ff;
    end
  end

  // save sequencer next state
  // a trigger in the reset cycle starts the next save at once; otherwise a request
  // written there would leave the request bit set with no save behind it
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      OSP_IDLE:  if (req_go || uv_go) nxt_state = OSP_SAVE;
      OSP_SAVE:  nxt_state = OSP_WAIT;
      OSP_WAIT:  if (save_done) nxt_state = OSP_RESET;
      OSP_RESET: nxt_state = (req_go || uv_go) ? OSP_SAVE : OSP_IDLE;
    endcase
  end

  // save sequencer; a request arriving during a save is folded into it
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= OSP_IDLE;
      by_req_ff <= 1'b0;
      save_req_ff <= 1'b0;
      save_start <= 1'b0;
      save_busy <= 1'b0;
      save_menu20 <= 1'b0;
      save_set_mask <= `OSP_RST_SET_MASK;
      module_reset <= 1'b0;
      drive_trip_clear <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      save_start <= (state_ff == OSP_SAVE);
      save_busy <= (nxt_state != OSP_IDLE);
      save_menu20 <= menu_en_ff;
      save_set_mask <= `OSP_RST_SET_MASK;
      module_reset <= (state_ff == OSP_RESET);
      drive_trip_clear <= (state_ff == OSP_RESET) && by_req_ff;
      if (take && req_go) by_req_ff <= 1'b1;
      else if (take && uv_go) by_req_ff <= 1'b0;
      if (req_go) save_req_ff <= 1'b1;
      else if (state_ff == OSP_RESET) save_req_ff <= 1'b0;
    end
  end

  // sync message generator: ms base, fast period, slow multiple of fast
  // limitation: counters restart at every reload, so the first fast tick comes
  // one full fast period after each module reset
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ms_cnt_ff <= 32'h0000_0000;
      fast_cnt_ff <= 7'h00;
      slow_cnt_ff <= 8'h00;
      sync_fast_tick <= 1'b0;
      sync_slow_tick <= 1'b0;
    end else begin
      sync_fast_tick <= fast_end;
      sync_slow_tick <= slow_end;
      if (!sync_on || init_ld) begin
        ms_cnt_ff <= 32'h0000_0000;
        fast_cnt_ff <= 7'h00;
        slow_cnt_ff <= 8'h00;
      end else begin
        ms_cnt_ff <= ms_tick ? 32'h0000_0000 : ms_cnt_ff + 32'h0000_0001;
        if (fast_end) fast_cnt_ff <= 7'h00;
        else if (ms_tick) fast_cnt_ff <= fast_cnt_ff + 7'h01;
        if (slow_end) slow_cnt_ff <= 8'h00;
        else if (fast_end) slow_cnt_ff <= slow_cnt_ff + 8'h01;
      end
    end
  end

  // read mux
  // settings read back the written value, not the cached copy, so software
  // sees a pending setting before the module reset that applies it
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (reg_addr)
      `OSP_OFS_WATCHDOG_KICK_COMMAND_EN:    rd_mux = {31'h0, wd_en_ff};
      `OSP_OFS_SAVE_REQ:   rd_mux = {31'h0, save_req_ff};
      `OSP_OFS_UV_SAVE:    rd_mux = {31'h0, uv_en_ff};
      `OSP_OFS_MENU_SAVE:  rd_mux = {31'h0, menu_en_ff};
      `OSP_OFS_RING_ID:    rd_mux = {24'h0, ring_ff};
      `OSP_OFS_NODE_ADDR:  rd_mux = {24'h0, node_ff};
      `OSP_OFS_DATA_RATE:  rd_mux = {30'h0, rate_ff};
      `OSP_OFS_SYNC_SETUP: rd_mux = {17'h0, sync_ff};
      8'h20:               rd_mux = {17'h0, dest_ff[0]};
      8'h24:               rd_mux = {17'h0, src_ff[0]};
      8'h28:               rd_mux = {17'h0, dest_ff[1]};
      8'h2C:               rd_mux = {17'h0, src_ff[1]};
      8'h30:               rd_mux = {17'h0, dest_ff[2]};
      8'h34:               rd_mux = {17'h0, src_ff[2]};
      8'h38:               rd_mux = {17'h0, inc_ff[0]};
      8'h3C:               rd_mux = {17'h0, inc_ff[1]};
      8'h40:               rd_mux = {17'h0, inc_ff[2]};
      `OSP_OFS_STATUS:     rd_mux = {29'h0, net_enable, save_busy, armed_ff};
      default:             rd_mux = 32'h0000_0000;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) rdata_ff <= 32'h0000_0000;
    else rdata_ff <= reg_rd ? rd_mux : 32'h0000_0000;
  end

  assign reg_rdata = rdata_ff;

endmodule

// ---- osp_setup_params_properties.sv ----
// port-level checks of the option setup bank
`timescale 1ns/100ps
`include "osp_map.svh"
module osp_setup_properties import osp_pkg::*; #(
  parameter int unsigned WATCHDOG_KICK_COMMAND_CYC = 200,
  parameter int unsigned MS_CYC   = 10
) (
  input wire logic                 ref_clk,
  input wire logic                 arst_n,
  input wire osp_pkg::osp_addr_t   reg_addr,
  input wire osp_pkg::osp_word_t   reg_wdata,
  input wire logic                 reg_wr,
  input wire logic                 watchdog_kick_command,
  input wire logic                 save_done,
  input wire logic                 slot_timeout_trip,
  input wire logic                 drive_trip_clear,
  input wire logic                 module_reset,
  input wire logic                 save_start,
  input wire logic                 save_busy,
  input wire logic                 save_menu20,
  input wire logic [3:0]           save_set_mask,
  input wire logic                 net_enable,
  input wire logic [7:0]           node_address_out,
  input wire logic [7:0]           bit_period_cyc,
  input wire logic                 sync_slow_tick,
  input wire logic                 sync_fast_tick
);
  logic [31:0] since_kick_ff;

  // cycles since the last kick; saturates so a trip with no kick at all is caught
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) since_kick_ff <= 32'hFFFFFFFF;
    else if (watchdog_kick_command) since_kick_ff <= 32'h0;
    else if (since_kick_ff != 32'hFFFFFFFF) since_kick_ff <= since_kick_ff + 32'h1;
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  AST_TRIP_TIME: assert property (
    slot_timeout_trip |-> since_kick_ff inside {[WATCHDOG_KICK_COMMAND_CYC:WATCHDOG_KICK_COMMAND_CYC+1]})
    else $error("watchdog trip at wrong distance from last kick");
  AST_TRIP_PULSE: assert property (slot_timeout_trip |=> !slot_timeout_trip)
    else $error("watchdog trip longer than one cycle");
  AST_SAVE_BUSY: assert property (
    reg_wr && reg_addr == `OSP_OFS_SAVE_REQ && reg_wdata[0] && !save_busy
    |=> save_busy ##1 save_start)
    else $error("save request did not start a save");
  AST_SAVE_MASK: assert property (save_start |-> save_set_mask == 4'hF)
    else $error("save set mask not the four register sets");
  AST_DONE_RESET: assert property (
    save_done && save_busy && !save_start && !$rose(save_busy) |-> ##[1:2] module_reset)
    else $error("no module reset after save completed");
  AST_BUSY_END: assert property ($fell(save_busy) |-> module_reset)
    else $error("save ended without module reset");
  AST_TRIP_CLEAR: assert property (drive_trip_clear |-> module_reset)
    else $error("trip clear outside module reset");
  AST_MENU20: assert property (
    reg_wr && reg_addr == `OSP_OFS_MENU_SAVE |-> ##2 save_menu20 == $past(reg_wdata[0], 2))
    else $error("menu save enable not applied at once");
  AST_NET_EN: assert property (net_enable |-> node_address_out != 8'h00)
    else $error("network enabled with node address zero");
  AST_RATE: assert property (bit_period_cyc inside {8'h14, 8'h28, 8'h50, 8'hA0})
    else $error("bit period not one of the four rates");
  AST_SLOW_TICK: assert property (sync_slow_tick |-> sync_fast_tick)
    else $error("slow sync tick off the fast grid");
endmodule

bind osp_setup_params osp_setup_properties #(
  .WATCHDOG_KICK_COMMAND_CYC (WATCHDOG_KICK_COMMAND_CYC),
  .MS_CYC   (MS_CYC)
) u_props (
  .ref_clk               (ref_clk),
  .arst_n                (arst_n),
  .reg_addr              (reg_addr),
  .reg_wdata             (reg_wdata),
  .reg_wr                (reg_wr),
  .watchdog_kick_command (watchdog_kick_command),
  .save_done             (save_done),
  .slot_timeout_trip     (slot_timeout_trip),
  .drive_trip_clear      (drive_trip_clear),
  .module_reset          (module_reset),
  .save_start            (save_start),
  .save_busy             (save_busy),
  .save_menu20           (save_menu20),
  .save_set_mask         (save_set_mask),
  .net_enable            (net_enable),
  .node_address_out      (node_address_out),
  .bit_period_cyc        (bit_period_cyc),
  .sync_slow_tick        (sync_slow_tick),
  .sync_fast_tick        (sync_fast_tick)
);

// ---- osp_drive_model.sv ----
// host drive model: answers each save with a one-cycle done pulse after a short wait
`timescale 1ns/100ps
module osp_drive_model (
  input wire logic  ref_clk,
  input wire logic  arst_n,
  input wire logic  save_start,
  input wire logic  slow_mode,
  output logic      save_done
);
  logic [3:0] wait_ff;
  logic       act_ff;

  // slow mode stretches the store so the sequencer must really wait
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      act_ff <= 1'b0;
      wait_ff <= 4'h0;
      save_done <= 1'b0;
    end else begin
      save_done <= 1'b0;
      if (save_start) begin
        act_ff <= 1'b1;
        wait_ff <= slow_mode ? 4'hA : 4'h1;
      end else if (act_ff) begin
        if (wait_ff == 4'h0) begin
          act_ff <= 1'b0;
          save_done <= 1'b1;
        end else wait_ff <= wait_ff - 4'h1;
      end
    end
  end
endmodule

// ---- tb_top.sv ----
// self-checking bench of the option setup bank
`timescale 1ns/100ps
`include "osp_map.svh"
module tb_top;
  import osp_pkg::*;
  localparam int unsigned W  = 200;
  localparam int unsigned MS = 10;
  logic ref_clk, arst_n, reg_wr, reg_rd, watchdog_kick_command, undervoltage_trip, slow_mode;
  logic save_done, slot_timeout_trip, drive_trip_clear, module_reset, save_start, save_busy;
  logic save_menu20, net_enable, sync_fast_tick, sync_slow_tick;
  logic [3:0] save_set_mask;
  logic [7:0] ring_identity_out, node_address_out, bit_period_cyc;
  logic [2:0][7:0] easy_dest_node;
  logic [2:0][6:0] easy_dest_slot, easy_src_menu, easy_src_param, easy_inc_menu, easy_inc_param;
  osp_addr_t reg_addr;
  osp_word_t reg_wdata, reg_rdata, d;
  int bad_count, n_tests, t;

  osp_setup_params #(.WATCHDOG_KICK_COMMAND_CYC(W), .MS_CYC(MS)) dut (.*);
  osp_drive_model u_drv (.*);

  always #5 ref_clk = ~ref_clk;

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %0h seen %0h", n, e, s);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic hang();
    bad_count++;
    print_verdict();
  endtask
  task automatic wr(input osp_addr_t a, input osp_word_t v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // read data is only valid in the cycle after the strobe
  task automatic rd(input osp_addr_t a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic kick();
    @(posedge ref_clk);
    watchdog_kick_command <= 1'b1;
    @(posedge ref_clk);
    watchdog_kick_command <= 1'b0;
  endtask
  task automatic wait_rst();
    int i;
    for (i = 0; i < 100 && module_reset !== 1'b1; i++) @(posedge ref_clk) #1;
    if (i == 100) hang();
  endtask
  task automatic watch(input int n);
    t = 0;
    repeat (n) begin
      @(posedge ref_clk) #1;
      if (slot_timeout_trip !== 1'b0) t++;
    end
  endtask
  // requested save doubles as the reinitialisation that loads cached settings
  task automatic reinit();
    wr(`OSP_OFS_SAVE_REQ, 32'h1);
    rd(`OSP_OFS_SAVE_REQ);
    chk("save_req_set", d, 32'h1);
    wait_rst();
    chk("trip_clear", drive_trip_clear, 1'b1);
    rd(`OSP_OFS_SAVE_REQ);
    chk("save_req_clr", d, 32'h0);
  endtask
  task automatic gap(input bit slow, output int n);
    int i;
    for (i = 0; i < 300 && (slow ? sync_slow_tick : sync_fast_tick) !== 1'b1; i++)
      @(posedge ref_clk) #1;
    if (i == 300) hang();
    n = 0;
    do begin
      @(posedge ref_clk) #1;
      n++;
    end while (n < 300 && (slow ? sync_slow_tick : sync_fast_tick) !== 1'b1);
    if (n == 300) hang();
  endtask

  task automatic t_reset_vals();
    chk("rate_rst", bit_period_cyc, 8'h28);
    wr(8'h48, 32'h5);
    wr(`OSP_OFS_STATUS, 32'h7);
    for (int a = 0; a <= 8'h48; a += 4) begin
      rd(8'(a));
      chk("reg_rst", d, (a == 8'h18) ? 32'h1 : 32'h0);
    end
  endtask
  task automatic t_easy();
    wr(8'h20, 32'd25503);
    wr(8'h28, 32'd30000);
    wr(8'h24, 32'd302);
    wr(8'h40, 32'd12000);
    wr(`OSP_OFS_SYNC_SETUP, 32'd10000);
    rd(8'h28);
    chk("dest_clamp", d, 32'd25503);
    rd(8'h40);
    chk("inc_clamp", d, 32'd9999);
    rd(`OSP_OFS_SYNC_SETUP);
    chk("sync_clamp", d, 32'd9999);
    reinit();
    @(posedge ref_clk) #1;
    chk("dest_node", easy_dest_node[0], 8'd255);
    chk("dest_slot", easy_dest_slot[0], 7'd3);
    chk("src_menu", easy_src_menu[0], 7'd3);
    chk("src_param", easy_src_param[0], 7'd2);
    chk("inc_menu", easy_inc_menu[2], 7'd99);
    chk("inc_param", easy_inc_param[2], 7'd99);
  endtask
  task automatic t_rate();
    for (int k = 0; k < 4; k++) begin
      // the other ring nodes are taken to carry the same rate code
      wr(`OSP_OFS_DATA_RATE, 32'(k));
      reinit();
      @(posedge ref_clk) #1;
      chk("bit_period", bit_period_cyc, 8'h14 << k);
    end
  endtask
  task automatic t_net();
    wr(`OSP_OFS_NODE_ADDR, 32'h5);
    wr(`OSP_OFS_RING_ID, 32'h7);
    chk("node_cached", node_address_out, 8'h00);
    reinit();
    @(posedge ref_clk) #1;
    chk("node", node_address_out, 8'h05);
    chk("ring", ring_identity_out, 8'h07);
    chk("net_on", net_enable, 1'b1);
    wr(`OSP_OFS_NODE_ADDR, 32'h0);
    reinit();
    @(posedge ref_clk) #1;
    chk("net_off", net_enable, 1'b0);
  endtask
  // this node alone generates sync: 3 ms fast, slow every 2 fast periods
  task automatic t_sync();
    int n;
    wr(`OSP_OFS_NODE_ADDR, 32'h5);
    wr(`OSP_OFS_SYNC_SETUP, 32'd203);
    reinit();
    gap(1'b0, n);
    chk("fast_gap", n, 3 * MS);
    gap(1'b1, n);
    chk("slow_gap", n, 6 * MS);
  endtask
  task automatic t_menu_uv();
    // this module is the only one on its drive that keeps the global menu
    wr(`OSP_OFS_MENU_SAVE, 32'h1);
    repeat (2) @(posedge ref_clk);
    #1 chk("menu20", save_menu20, 1'b1);
    @(posedge ref_clk);
    undervoltage_trip <= 1'b1;
    repeat (20) @(posedge ref_clk);
    #1 chk("uv_off", save_busy, 1'b0);
    @(posedge ref_clk);
    undervoltage_trip <= 1'b0;
    slow_mode <= 1'b1;
    wr(`OSP_OFS_UV_SAVE, 32'h1);
    repeat (4) @(posedge ref_clk);
    undervoltage_trip <= 1'b1;
    wait_rst();
    chk("uv_no_clear", drive_trip_clear, 1'b0);
    @(posedge ref_clk);
    undervoltage_trip <= 1'b0;
    slow_mode <= 1'b0;
  endtask
  // kicks come well inside the period, as a healthy program would
  task automatic t_watchdog_kick_command();
    int n;
    wr(`OSP_OFS_WATCHDOG_KICK_COMMAND_EN, 32'h1);
    reinit();
    watch(300);
    chk("no_arm", t, 0);
    kick();
    watch(150);
    chk("armed_ok", t, 0);
    rd(`OSP_OFS_STATUS);
    chk("armed", d[`OSP_ST_ARMED], 1'b1);
    kick();
    // counted from the edge that took the kick: the trip shows W edges later
    n = 0;
    do begin
      @(posedge ref_clk) #1;
      n++;
    end while (n < 400 && slot_timeout_trip !== 1'b1);
    if (n == 400) hang();
    chk("trip_time", n, W);
    watch(300);
    chk("disarmed", t, 0);
  endtask

  initial begin
    ref_clk = 1'b0;
    arst_n = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    watchdog_kick_command = 1'b0;
    undervoltage_trip = 1'b0;
    slow_mode = 1'b0;
    bad_count = 0;
    n_tests = 0;
    repeat (8) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(posedge ref_clk) #1;
    t_reset_vals();
    t_easy();
    t_rate();
    t_net();
    t_sync();
    t_menu_uv();
    t_watchdog_kick_command();
    print_verdict();
  end
endmodule
